// *** dv/tmc_top_test.sv ***
// self-checking bench for the transmit control register and identification bytes
`timescale 1ns/10ps
module tx_mapper_control_and_id_test;
  import tmc_pkg::*;
  localparam logic [3:0] VER = 4'h3; // arbitrary value
  localparam logic [15:0] PART = 16'h1234; // arbitrary value
  localparam logic [10:0] MAKER = 11'h155; // arbitrary value
  localparam logic [3:0] MASK = 4'h6; // arbitrary value
  localparam logic [3:0] GROW = 4'h9; // arbitrary value
  logic clk = 0, rst = 1, wr = 0, rd = 0, lclk = 0, far_en = 0, rdi_en = 0, irdi = 0, prdi = 0, pin = 0;
  logic obit_in = 0, uneq = 0, ais, ob, rdi, zpoh, zpay;
  logic [5:0] al = 0; // loss alarm and enable pairs
  logic [3:0] ifebe = 0, pfebe = 0, febe;
  logic [7:0] addr = 0, wdata = 0, ldata = 0, calc = 8'h5a, pat = 8'h0f, rdata, lout, b3;
  logic [7:0] idv [5];
  int n_errors = 0, samples_checked = 0;
  always #25 clk = ~clk;
  tmc_top #(.ID_VERSION(VER), .ID_PART_NUMBER(PART), .ID_MAKER(MAKER), .ID_MASK_LEVEL(MASK), .ID_GROWTH(GROW))
  tmc_top_inst (.clk(clk), .rst(rst), .cpu_addr(addr), .cpu_wdata(wdata), .cpu_wr(wr), .cpu_rd(rd),
    .cpu_rdata(rdata), .tx_line_clock(lclk), .tx_line_data(ldata), .ext_signal_loss_alarm(al[5]),
    .ext_loss_ais_en(al[4]), .tx_clock_loss_alarm(al[3]), .clock_loss_ais_en(al[2]), .frame_loss_alarm(al[1]),
    .frame_loss_ais_en(al[0]), .far_block_error_en(far_en), .remote_defect_en(rdi_en), .int_febe_count(ifebe),
    .int_rdi(irdi), .alarm_port_febe(pfebe), .alarm_port_rdi(prdi), .tx_alarm_input_pin(pin),
    .ext_obit_in(obit_in), .calc_b3(calc), .b3_pattern(pat), .tx_unequipped(uneq), .line_data_out(lout),
    .line_ais(ais), .obit_out(ob), .b3_out(b3), .g1_febe_out(febe), .g1_rdi_out(rdi), .zero_poh(zpoh),
    .zero_payload(zpay));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask : wreg
  // write then read in the very next cycle
  task automatic wrd(input logic [7:0] d, input logic [7:0] exp);
    @(negedge clk);
    addr = ADDR_TRANSMIT_CONTROL;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
    rd = 1;
    @(negedge clk);
    rd = 0;
    check(rdata, exp);
  endtask : wrd
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    @(negedge clk);
    check(rdata, exp);
  endtask : rchk
  // covers the three-stage pin synchronisers with margin
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask : settle
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    idv = '{{MAKER[6:0], 1'b1}, {PART[3:0], MAKER[10:7]}, PART[11:4], {VER, 4'h0}, {MASK, GROW}};
    repeat (8) @(negedge clk);
    rst = 0;
    rchk(ADDR_TRANSMIT_CONTROL, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wreg(8'(i), ~idv[i]);
      rchk(8'(i), idv[i]);
    end
    rchk(8'h20, 8'h00);
    wreg(ADDR_TRANSMIT_CONTROL, 8'hff);
    rchk(ADDR_TRANSMIT_CONTROL, 8'hfe);
    wrd(8'h5b, 8'h5a);
    $display("register test done");
    wreg(ADDR_TRANSMIT_CONTROL, 8'h40);
    al = 6'b101010;
    settle();
    check(8'(ais), 8'h01);
    check(lout, LINE_ALL_ONES);
    wreg(ADDR_TRANSMIT_CONTROL, 8'h00);
    for (int k = 0; k < 3; k++) begin
      al = 6'b000010 << (2 * k);
      settle();
      check(8'(ais), 8'h00);
      al = 6'b000011 << (2 * k);
      settle();
      check(8'(ais), 8'h01);
    end
    al = 0;
    $display("line ais test done");
    obit_in = 1;
    settle();
    check(8'(ob), 8'h00);
    wreg(ADDR_TRANSMIT_CONTROL, 8'h10);
    settle();
    check(8'(ob), 8'h01);
    obit_in = 0;
    settle();
    check(8'(ob), 8'h00);
    wreg(ADDR_TRANSMIT_CONTROL, 8'h08);
    settle();
    check(b3, pat);
    wreg(ADDR_TRANSMIT_CONTROL, 8'h00);
    settle();
    check(b3, calc ^ pat);
    $display("overhead bit and parity test done");
    rdi_en = 1;
    pin = 1;
    settle();
    check(8'(rdi), 8'h00);
    wreg(ADDR_TRANSMIT_CONTROL, 8'h04);
    settle();
    check(8'(rdi), 8'h01);
    pin = 0;
    far_en = 1;
    pfebe = 4'hc;
    prdi = 1;
    ifebe = 4'h3;
    wreg(ADDR_TRANSMIT_CONTROL, 8'h20);
    settle();
    check({febe, 3'h0, rdi}, 8'hc1);
    wreg(ADDR_TRANSMIT_CONTROL, 8'h00);
    settle();
    check({febe, 3'h0, rdi}, 8'h30);
    $display("g1 test done");
    uneq = 1;
    settle();
    check({6'h00, zpoh, zpay}, 8'h03);
    wreg(ADDR_TRANSMIT_CONTROL, 8'h02);
    settle();
    check({6'h00, zpoh, zpay}, 8'h01);
    uneq = 0;
    settle();
    check({6'h00, zpoh, zpay}, 8'h00);
    $display("unequipped test done");
    wreg(ADDR_TRANSMIT_CONTROL, 8'h00);
    ldata = 8'ha1;
    lclk = 1;
    settle();
    check(lout, 8'ha1);
    ldata = 8'hb2;
    lclk = 0;
    settle();
    check(lout, 8'ha1);
    wreg(ADDR_TRANSMIT_CONTROL, 8'h80);
    ldata = 8'hc3;
    lclk = 1;
    settle();
    check(lout, 8'ha1);
    lclk = 0;
    settle();
    check(lout, 8'hc3);
    $display("line clock edge test done");
    close_out();
  end
endmodule : tx_mapper_control_and_id_test

// *** hdl/tmc_pkg.sv ***
// constants and state type for the transmit mapper control and id registers
package tmc_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_MAKER_ID_LOW = 8'h00;
  localparam logic [7:0] ADDR_PART_ID_LOW = 8'h01;
  localparam logic [7:0] ADDR_PART_ID_HIGH = 8'h02;
  localparam logic [7:0] ADDR_REVISION_LEVEL = 8'h03;
  localparam logic [7:0] ADDR_MASK_LEVEL_GROWTH = 8'h04;
  localparam logic [7:0] ADDR_TRANSMIT_CONTROL = 8'h10;
  // transmit_control bit positions
  localparam int BIT_TX_CLOCK_EDGE_INVERT = 7;
  localparam int BIT_FORCE_LINE_ALL_ONES = 6;
  localparam int BIT_RING_MODE = 5;
  localparam int BIT_EXT_OVERHEAD_BITS_EN = 4;
  localparam int BIT_PARITY_BYTE_TEST = 3;
  localparam int BIT_PIN_DRIVEN_REMOTE_DEFECT_EN = 2;
  localparam int BIT_OVERHEAD_DURING_UNEQUIPPED = 1;
  localparam logic [7:0] TRANSMIT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WRITABLE_MASK = 8'hfe;
  localparam logic [7:0] LINE_ALL_ONES = 8'hff;
  localparam logic [3:0] REVISION_LOW_ZERO = 4'h0;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic [2:0] clk_sync;
    logic [2:0] alarm_sync;
    logic [2:0] obit_sync;
    logic alarm_level;
    logic obit_level;
    logic [DATA_W-1:0] data_s1;
    logic [DATA_W-1:0] data_s2;
    logic [DATA_W-1:0] data_s3;
    logic clk_level;
    logic [DATA_W-1:0] line_out;
    logic line_ais;
    logic obit_out;
    logic [7:0] b3_out;
    logic [3:0] febe_out;
    logic rdi_out;
    logic zero_poh;
    logic zero_payload;
  } tmc_state_t;
endpackage : tmc_pkg

// *** hdl/tmc_top.sv ***
// transmit control register, identification bytes and the transmit line actions they steer
// Behaviour
// - identifier ordered version, part number, maker, then a constant one bit.
// - maker and the low twelve part number bits offered as read-only bytes at addresses 0 to 2.
// - identification bytes ignore writes; address 3 holds revision, low nibble zero.
// - address 4 is read-only: mask level high nibble, growth low nibble.
// - line data sampled on rising clock edge, or falling when invert bit set.
// - forced line all-ones replaces line data regardless of alarms and enables.
// - automatic line all-ones on enabled signal loss, clock loss or frame loss.
// - ring mode lets the alarm port drive enabled far block errors and RDI.
// - external overhead bits taken from the serial input, else sent as zero.
// - parity test bit sends the software pattern byte instead of calculated B3.
// - otherwise each set pattern bit inverts the matching calculated B3 bit.
// - both RDI enables set and alarm pin high sends path RDI.
// - unequipped without overhead bit zeroes overhead and payload.
// - unequipped with overhead bit keeps overhead, zeroes payload.
`timescale 1ns/10ps
module tmc_top
  import tmc_pkg::*;
#(
  parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
  parameter logic [15:0] ID_PART_NUMBER = 16'h5a3c, // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h2a5, // arbitrary value
  parameter logic [3:0] ID_MASK_LEVEL = 4'h1, // arbitrary value
  parameter logic [3:0] ID_GROWTH = 4'h0 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  input wire logic tx_line_clock,
  input wire logic [DATA_W-1:0] tx_line_data,
  input wire logic ext_signal_loss_alarm,
  input wire logic ext_loss_ais_en,
  input wire logic tx_clock_loss_alarm,
  input wire logic clock_loss_ais_en,
  input wire logic frame_loss_alarm,
  input wire logic frame_loss_ais_en,
  input wire logic far_block_error_en,
  input wire logic remote_defect_en,
  input wire logic [3:0] int_febe_count,
  input wire logic int_rdi,
  input wire logic [3:0] alarm_port_febe,
  input wire logic alarm_port_rdi,
  input wire logic tx_alarm_input_pin,
  input wire logic ext_obit_in,
  input wire logic [7:0] calc_b3,
  input wire logic [7:0] b3_pattern,
  input wire logic tx_unequipped,
  output logic [DATA_W-1:0] line_data_out,
  output logic line_ais,
  output logic obit_out,
  output logic [7:0] b3_out,
  output logic [3:0] g1_febe_out,
  output logic g1_rdi_out,
  output logic zero_poh,
  output logic zero_payload
);

  localparam logic [31:0] SERIAL_ID = {ID_VERSION, ID_PART_NUMBER, ID_MAKER, 1'b1};

  tmc_state_t st;
  tmc_state_t next_st;

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] ctrl);
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      ADDR_MAKER_ID_LOW: val = SERIAL_ID[7:0];
      ADDR_PART_ID_LOW: val = SERIAL_ID[15:8];
      ADDR_PART_ID_HIGH: val = SERIAL_ID[23:16];
      ADDR_REVISION_LEVEL: val = {ID_VERSION, REVISION_LOW_ZERO};
      ADDR_MASK_LEVEL_GROWTH: val = {ID_MASK_LEVEL, ID_GROWTH};
      ADDR_TRANSMIT_CONTROL: val = ctrl & CTRL_WRITABLE_MASK;
      default: val = 8'h00;
    endcase
    return val;
  endfunction : read_mux

  logic clk_edge;
  logic take_sample;
  logic auto_ais;
  logic any_ais;
  logic ring;
  logic unequipped_full;

  always_comb begin
    next_st = st;
    // only the control byte is writable, id bytes drop writes
    if (cpu_wr && cpu_addr == ADDR_TRANSMIT_CONTROL) begin
      next_st.ctrl = cpu_wdata & CTRL_WRITABLE_MASK;
    end
    if (cpu_rd) begin
      next_st.rdata = read_mux(cpu_addr, st.ctrl);
    end
    next_st.clk_sync = {st.clk_sync[1:0], tx_line_clock};
    next_st.alarm_sync = {st.alarm_sync[1:0], tx_alarm_input_pin};
    next_st.obit_sync = {st.obit_sync[1:0], ext_obit_in};
    // a pin level counts only once the last two stages agree, so a metastable first stage never leaks
    if (st.alarm_sync[1] == st.alarm_sync[2]) begin
      next_st.alarm_level = st.alarm_sync[2];
    end
    if (st.obit_sync[1] == st.obit_sync[2]) begin
      next_st.obit_level = st.obit_sync[2];
    end
    // data rides the same three stages so it stays aligned with the clock edge
    next_st.data_s1 = tx_line_data;
    next_st.data_s2 = st.data_s1;
    next_st.data_s3 = st.data_s2;
    clk_edge = (st.clk_sync[1] == st.clk_sync[2]) && (st.clk_sync[2] != st.clk_level);
    if (clk_edge) begin
      next_st.clk_level = st.clk_sync[2];
    end
    // rising edge is a new level of one
    take_sample = clk_edge && (st.clk_sync[2] != st.ctrl[BIT_TX_CLOCK_EDGE_INVERT]);
    auto_ais = (ext_signal_loss_alarm && ext_loss_ais_en)
             || (tx_clock_loss_alarm && clock_loss_ais_en)
             || (frame_loss_alarm && frame_loss_ais_en);
    any_ais = st.ctrl[BIT_FORCE_LINE_ALL_ONES] || auto_ais;
    next_st.line_ais = any_ais;
    if (any_ais) begin
      next_st.line_out = LINE_ALL_ONES;
    end else if (take_sample) begin
      next_st.line_out = st.data_s3;
    end
    next_st.obit_out = st.ctrl[BIT_EXT_OVERHEAD_BITS_EN] && st.obit_level;
    if (st.ctrl[BIT_PARITY_BYTE_TEST]) begin
      next_st.b3_out = b3_pattern;
    end else begin
      next_st.b3_out = calc_b3 ^ b3_pattern;
    end
    ring = st.ctrl[BIT_RING_MODE];
    next_st.febe_out = far_block_error_en ? (ring ? alarm_port_febe : int_febe_count) : 4'h0;
    next_st.rdi_out = remote_defect_en && ((ring ? alarm_port_rdi : int_rdi)
                    || (st.ctrl[BIT_PIN_DRIVEN_REMOTE_DEFECT_EN] && st.alarm_level));
    // supervisory mode is set by control bit 1: overhead kept, only the payload zeroed
    unequipped_full = tx_unequipped && !st.ctrl[BIT_OVERHEAD_DURING_UNEQUIPPED];
    next_st.zero_poh = unequipped_full;
    next_st.zero_payload = tx_unequipped;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= TRANSMIT_CONTROL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cpu_rdata = st.rdata;
  assign line_data_out = st.line_out;
  assign line_ais = st.line_ais;
  assign obit_out = st.obit_out;
  assign b3_out = st.b3_out;
  assign g1_febe_out = st.febe_out;
  assign g1_rdi_out = st.rdi_out;
  assign zero_poh = st.zero_poh;
  assign zero_payload = st.zero_payload;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence ctrl_write_s;
    cpu_wr && cpu_addr == ADDR_TRANSMIT_CONTROL && !cpu_rd;
  endsequence
  sequence ctrl_read_s;
    cpu_rd && cpu_addr == ADDR_TRANSMIT_CONTROL && !cpu_wr;
  endsequence

  ctrl_write_read_a: assert property (ctrl_write_s ##1 ctrl_read_s |=>
    cpu_rdata == ($past(cpu_wdata, 2) & CTRL_WRITABLE_MASK))
    else $error("control byte did not read back");
  maker_byte_a: assert property (cpu_rd && cpu_addr == ADDR_MAKER_ID_LOW |=>
    cpu_rdata[0] == 1'b1 && cpu_rdata == SERIAL_ID[7:0])
    else $error("maker byte wrong");
  part_high_a: assert property (cpu_rd && cpu_addr == ADDR_PART_ID_HIGH |=>
    cpu_rdata == SERIAL_ID[23:16])
    else $error("part high byte wrong");
  revision_nibble_a: assert property (cpu_rd && cpu_addr == ADDR_REVISION_LEVEL |=>
    cpu_rdata == {ID_VERSION, 4'h0})
    else $error("revision byte wrong");
  mask_growth_a: assert property (cpu_rd && cpu_addr == ADDR_MASK_LEVEL_GROWTH |=>
    cpu_rdata == {ID_MASK_LEVEL, ID_GROWTH})
    else $error("mask level byte wrong");
  forced_ais_a: assert property (st.ctrl[BIT_FORCE_LINE_ALL_ONES] |=>
    line_data_out == LINE_ALL_ONES && line_ais)
    else $error("forced all ones missing");
  auto_ais_a: assert property (frame_loss_alarm && frame_loss_ais_en |=> line_ais)
    else $error("frame loss did not raise all ones");
  obit_zero_a: assert property (!st.ctrl[BIT_EXT_OVERHEAD_BITS_EN] |=> !obit_out)
    else $error("overhead bit not zero");
  b3_mask_a: assert property (!st.ctrl[BIT_PARITY_BYTE_TEST] |=>
    b3_out == ($past(calc_b3) ^ $past(b3_pattern)))
    else $error("parity mask wrong");
  b3_test_a: assert property (st.ctrl[BIT_PARITY_BYTE_TEST] |=> b3_out == $past(b3_pattern))
    else $error("parity test byte wrong");
  pin_rdi_a: assert property (remote_defect_en && st.ctrl[BIT_PIN_DRIVEN_REMOTE_DEFECT_EN]
    && st.alarm_level |=> g1_rdi_out)
    else $error("pin rdi not sent");
  ring_febe_a: assert property (ring && far_block_error_en |=> g1_febe_out == $past(alarm_port_febe))
    else $error("ring febe wrong");
  supervisory_a: assert property (tx_unequipped && st.ctrl[BIT_OVERHEAD_DURING_UNEQUIPPED]
    |=> zero_payload && !zero_poh)
    else $error("supervisory unequipped wrong");
  unequipped_a: assert property (tx_unequipped && !st.ctrl[BIT_OVERHEAD_DURING_UNEQUIPPED]
    |=> zero_payload && zero_poh)
    else $error("unequipped wrong");
  sample_edge_a: assert property (take_sample && !any_ais |=> line_data_out == $past(st.data_s3))
    else $error("line sample missed");

  sequence line_rise_s;
    st.clk_sync[2] && st.clk_sync[1] && !st.clk_level;
  endsequence
  sequence line_fall_s;
    !st.clk_sync[2] && !st.clk_sync[1] && st.clk_level;
  endsequence

  rise_sample_a: assert property (line_rise_s ##0 (!st.ctrl[BIT_TX_CLOCK_EDGE_INVERT] && !any_ais)
    |=> line_data_out == $past(st.data_s3))
    else $error("rising edge sample missed");
  fall_sample_a: assert property (line_fall_s ##0 (st.ctrl[BIT_TX_CLOCK_EDGE_INVERT] && !any_ais)
    |=> line_data_out == $past(st.data_s3))
    else $error("falling edge sample missed");
  no_sample_hold_a: assert property (!take_sample && !any_ais |=> $stable(line_data_out))
    else $error("line data moved without an edge");
  part_low_a: assert property (cpu_rd && cpu_addr == ADDR_PART_ID_LOW |=>
    cpu_rdata == SERIAL_ID[15:8])
    else $error("part low byte wrong");
  unmapped_read_a: assert property (cpu_rd && cpu_addr > ADDR_MASK_LEVEL_GROWTH
    && cpu_addr != ADDR_TRANSMIT_CONTROL |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  id_write_ignored_a: assert property (cpu_wr && cpu_addr != ADDR_TRANSMIT_CONTROL |=>
    st.ctrl == $past(st.ctrl))
    else $error("write outside control changed it");
  ctrl_hold_a: assert property (!cpu_wr |=> $stable(st.ctrl))
    else $error("control changed without a write");
  ctrl_bit0_a: assert property (!st.ctrl[0])
    else $error("control bit 0 stored");
  rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data moved without a read");
  ais_flag_a: assert property (any_ais |=> line_ais && line_data_out == LINE_ALL_ONES)
    else $error("all ones not sent");
  no_ais_a: assert property (!any_ais |=> !line_ais)
    else $error("all ones without cause");
  ext_loss_ais_a: assert property (ext_signal_loss_alarm && ext_loss_ais_en |=> line_ais)
    else $error("signal loss did not raise all ones");
  clock_loss_ais_a: assert property (tx_clock_loss_alarm && clock_loss_ais_en |=> line_ais)
    else $error("clock loss did not raise all ones");
  obit_follow_a: assert property (st.ctrl[BIT_EXT_OVERHEAD_BITS_EN] |=>
    obit_out == $past(st.obit_level))
    else $error("overhead bit not passed");
  ring_rdi_a: assert property (ring && remote_defect_en && alarm_port_rdi |=> g1_rdi_out)
    else $error("ring rdi not sent");
  local_febe_a: assert property (!ring && far_block_error_en |=>
    g1_febe_out == $past(int_febe_count))
    else $error("local febe wrong");
  febe_off_a: assert property (!far_block_error_en |=> g1_febe_out == 4'h0)
    else $error("febe sent while disabled");
  rdi_off_a: assert property (!remote_defect_en |=> !g1_rdi_out)
    else $error("rdi sent while disabled");
  pin_ignored_a: assert property (remote_defect_en && !st.ctrl[BIT_PIN_DRIVEN_REMOTE_DEFECT_EN]
    && !(ring ? alarm_port_rdi : int_rdi) |=> !g1_rdi_out)
    else $error("pin drove rdi while disabled");
  normal_traffic_a: assert property (!tx_unequipped |=> !zero_payload && !zero_poh)
    else $error("zeroing in normal operation");

endmodule : tmc_top
